// ===== ppd_defines.svh
// Register offsets, reset values and mode codes of the parallel port block
`ifndef PPD_DEFINES_SVH
`define PPD_DEFINES_SVH

// ============================================================
// Register map
`define PPD_ADDR_W         16
`define PPD_OFS_P1_DIR     16'hFFB0
`define PPD_OFS_P2_DIR     16'hFFB1
`define PPD_OFS_P1_LATCH   16'hFFB2
`define PPD_OFS_P2_LATCH   16'hFFB3
`define PPD_OFS_P3_DIR     16'hFFB4

// ============================================================
// Reset and read values
`define PPD_DIR_RST        8'h00
`define PPD_DIR_LOCKED     8'hFF
`define PPD_LATCH_RST      8'h00
`define PPD_RD_NONE        8'h00

// ============================================================
// Operating modes
`define PPD_MODE_W         2
`define PPD_MODE_1         2'h1
`define PPD_MODE_RST       2'h3

`endif

// ===== ppd_pins_model.sv
// Board pins with pull-ups on all 24 port lines
`timescale 1ns/100ps

module ppd_pins_model (
	// Device side
	input  wire logic [23:0] drv_i,
	input  wire logic [23:0] oe_i,
	// Pin levels
	output logic      [23:0] lvl_o
);
	assign lvl_o = (drv_i & oe_i) | ~oe_i;
endmodule

// ===== ppd_pkg.sv
// Types shared by the parallel port block
package ppd_pkg;

	// ============================================================
	// Port selection
	typedef enum logic [2:0] {
		PPD_SEL_NONE = 3'h0,
		PPD_SEL_P1   = 3'h1,
		PPD_SEL_P2   = 3'h2,
		PPD_SEL_P3   = 3'h4
	} ppd_sel_type;

	typedef logic [7:0] ppd_byte_type;

endpackage

// ===== ppd_port.sv
// One eight-pin port slice: direction register and output latch
`timescale 1ns/100ps
`include "ppd_defines.svh"

module ppd_port #(
	parameter bit HAS_LATCH = 1'b1
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	// Register side
	ppd_port_if.port  pif
);

	ppd_pkg::ppd_byte_type dir_q;
	ppd_pkg::ppd_byte_type latch_q;

	// ============================================================
	// Direction register, write only
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dir_q <= `PPD_DIR_RST;
		end else if (pif.wr_dir && !pif.locked) begin
			dir_q <= pif.wdata;
		end
	end

	// Locked ports stand as all outputs
	assign pif.dir = pif.locked ? `PPD_DIR_LOCKED : dir_q;

	// ============================================================
	// Output latch
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			latch_q <= `PPD_LATCH_RST;
		end else if (pif.wr_latch && HAS_LATCH) begin
			latch_q <= pif.wdata;
		end
	end

	assign pif.latch = latch_q;

endmodule

// ===== ppd_port_if.sv
// Carrier between the register decode and one port slice
`timescale 1ns/100ps

interface ppd_port_if;
	ppd_pkg::ppd_byte_type wdata;
	logic                  wr_dir;
	logic                  wr_latch;
	logic                  locked;
	ppd_pkg::ppd_byte_type dir;
	ppd_pkg::ppd_byte_type latch;

	modport ctrl (
		output wdata,
		output wr_dir,
		output wr_latch,
		output locked,
		input  dir,
		input  latch
	);

	modport port (
		input  wdata,
		input  wr_dir,
		input  wr_latch,
		input  locked,
		output dir,
		output latch
	);
endinterface

// ===== ppd_top.sv
// Parallel ports 1 to 3: direction registers, data registers of ports 1 and 2, pin drivers
//
// Notes on behaviour
// - direction bit 0 makes the pin an input, 1 an output.
// - ports 1, 2 directions all ones and locked in mode 1, else zero, writable.
// - port 3 direction resets to zero in every mode, write only.
// - ports 1, 2 data latches are eight bits, read-write, reset to zero.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`include "ppd_defines.svh"

module ppd_top (
	// Clock and reset
	input  wire logic                      core_clk_i,
	input  wire logic                      nrst_i,
	// Mode strap
	input  wire logic [`PPD_MODE_W-1:0]    mode_i,
	// Register port
	input  wire logic [`PPD_ADDR_W-1:0]    addr_i,
	input  wire logic [7:0]                wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic      [7:0]                rdata_o,
	// Port 3 output value from its own data register
	input  wire logic [7:0]                p3_out_value_i,
	// Pins
	input  wire logic [7:0]                p1_pin_i,
	output logic      [7:0]                p1_pin_o,
	output logic      [7:0]                p1_pin_oe_o,
	input  wire logic [7:0]                p2_pin_i,
	output logic      [7:0]                p2_pin_o,
	output logic      [7:0]                p2_pin_oe_o,
	input  wire logic [7:0]                p3_pin_i,
	output logic      [7:0]                p3_pin_o,
	output logic      [7:0]                p3_pin_oe_o
);

	localparam int NPORT = 3;

	ppd_port_if            pif [NPORT] ();
	ppd_pkg::ppd_sel_type  sel;
	logic                  mode_taken;
	logic                  mode1_q;
	logic                  mode1;
	ppd_pkg::ppd_byte_type next_rdata;
	ppd_pkg::ppd_byte_type rdata_q;

	// ============================================================
	// Address decode
	function automatic ppd_pkg::ppd_sel_type dir_sel(
		input logic [`PPD_ADDR_W-1:0] a
	);
		unique case (a)
			`PPD_OFS_P1_DIR:   dir_sel = ppd_pkg::PPD_SEL_P1;
			`PPD_OFS_P2_DIR:   dir_sel = ppd_pkg::PPD_SEL_P2;
			`PPD_OFS_P3_DIR:   dir_sel = ppd_pkg::PPD_SEL_P3;
			default:           dir_sel = ppd_pkg::PPD_SEL_NONE;
		endcase
	endfunction

	function automatic ppd_pkg::ppd_sel_type latch_sel(
		input logic [`PPD_ADDR_W-1:0] a
	);
		unique case (a)
			`PPD_OFS_P1_LATCH: latch_sel = ppd_pkg::PPD_SEL_P1;
			`PPD_OFS_P2_LATCH: latch_sel = ppd_pkg::PPD_SEL_P2;
			default:           latch_sel = ppd_pkg::PPD_SEL_NONE;
		endcase
	endfunction

	assign sel = latch_sel(addr_i);

	// ============================================================
	// Mode strap, caught at the first edge after reset release
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_taken <= 1'b0;
			mode1_q    <= 1'b0;
		end else if (!mode_taken) begin
			mode_taken <= 1'b1;
			mode1_q    <= (mode_i == `PPD_MODE_1);
		end
	end

	// Before the capture the live strap decides
	assign mode1 = mode_taken ? mode1_q : (mode_i == `PPD_MODE_1);

	// ============================================================
	// Port slices
	for (genvar g = 0; g < NPORT; g++) begin : g_port
		localparam logic [2:0] BIT = 3'(1 << g);
		assign pif[g].wdata    = wdata_i;
		assign pif[g].wr_dir   = wr_i && ((dir_sel(addr_i) & BIT) != 3'h0);
		assign pif[g].wr_latch = wr_i && ((sel & BIT) != 3'h0);
		assign pif[g].locked   = (g < 2) ? mode1 : 1'b0;
		ppd_port #(
			.HAS_LATCH (g < 2)
		) u_port (
			.core_clk_i (core_clk_i),
			.nrst_i     (nrst_i),
			.pif        (pif[g])
		);
	end

	// ============================================================
	// Read path, data one cycle after the strobe
	always_comb begin
		next_rdata = `PPD_RD_NONE;
		if (rd_i) begin
			unique case (sel)
				ppd_pkg::PPD_SEL_P1:
					next_rdata = pif[0].latch;
				ppd_pkg::PPD_SEL_P2:
					next_rdata = pif[1].latch;
				default:
					next_rdata = `PPD_RD_NONE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= `PPD_RD_NONE;
		end else begin
			rdata_q <= next_rdata;
		end
	end

	assign rdata_o = rdata_q;

	// ============================================================
	// Pin drivers
	assign p1_pin_o    = pif[0].latch;
	assign p1_pin_oe_o = pif[0].dir;
	assign p2_pin_o    = pif[1].latch;
	assign p2_pin_oe_o = pif[1].dir;
	assign p3_pin_o    = p3_out_value_i;
	assign p3_pin_oe_o = pif[2].dir;

endmodule

// ===== ppd_top_asserts.sv
// Checker of the parallel port block
`timescale 1ns/100ps

module ppd_top_asserts (
	// Clock, reset, requests
	input wire logic        core_clk_i,
	input wire logic        nrst_i,
	input wire logic [1:0]  mode_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	// Outputs
	input wire logic [7:0]  rdata_o,
	input wire logic [7:0]  p1_pin_o,
	input wire logic [7:0]  p1_pin_oe_o,
	input wire logic [7:0]  p2_pin_oe_o,
	input wire logic [7:0]  p3_pin_oe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// ============================================================
	// Properties
	property p_dir3;
		wr_i && addr_i == 16'hFFB4 |=> p3_pin_oe_o == $past(wdata_i);
	endproperty
	a_dir3: assert property (p_dir3) else $error("p3 dir");
	property p_lock;
		mode_i == 2'h1 |-> p1_pin_oe_o == 8'hFF && p2_pin_oe_o == 8'hFF;
	endproperty
	a_lock: assert property (p_lock) else $error("lock");
	property p_wo;
		rd_i && addr_i == 16'hFFB4 |=> rdata_o == 8'h00;
	endproperty
	a_wo: assert property (p_wo) else $error("wo read");
	property p_rdl;
		rd_i && addr_i == 16'hFFB2 |=> rdata_o == $past(p1_pin_o);
	endproperty
	a_rdl: assert property (p_rdl) else $error("latch read");
	property p_wrl;
		wr_i && addr_i == 16'hFFB2 |=> p1_pin_o == $past(wdata_i);
	endproperty
	a_wrl: assert property (p_wrl) else $error("latch write");
endmodule

bind ppd_top ppd_top_asserts u_chk (.core_clk_i, .nrst_i, .mode_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .p1_pin_o, .p1_pin_oe_o,
	.p2_pin_oe_o, .p3_pin_oe_o);

// ===== ppd_top_tb.sv
// Testbench of the parallel port block
`timescale 1ns/100ps

module ppd_top_tb;
	logic        core_clk_i = 0;
	logic        nrst_i = 0;
	logic [1:0]  mode_i = 2'h3;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 0;
	logic        rd_i = 0;
	logic [7:0]  p3_val = 8'h96;
	logic [7:0]  q;
	wire  [7:0]  rdata_o, p1_o, p1_oe, p2_o, p2_oe, p3_o, p3_oe;
	wire  [23:0] pin;
	int          n_fail = 0;
	int          checks_done = 0;
	always #50 core_clk_i = ~core_clk_i;
	ppd_top DUT (.core_clk_i, .nrst_i, .mode_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .p3_out_value_i(p3_val), .p1_pin_i(pin[7:0]),
		.p1_pin_o(p1_o), .p1_pin_oe_o(p1_oe), .p2_pin_i(pin[15:8]),
		.p2_pin_o(p2_o), .p2_pin_oe_o(p2_oe), .p3_pin_i(pin[23:16]),
		.p3_pin_o(p3_o), .p3_pin_oe_o(p3_oe));
	ppd_pins_model u_pins (.drv_i({p3_o, p2_o, p1_o}),
		.oe_i({p3_oe, p2_oe, p1_oe}), .lvl_o(pin));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		wr_i <= 1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 0;
	endtask
	task rd(input logic [15:0] a);
		@(posedge core_clk_i);
		rd_i <= 1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 0;
		@(negedge core_clk_i);
		q = rdata_o;
	endtask
	task t_reset(input logic [1:0] m, input logic [7:0] oe);
		@(posedge core_clk_i);
		nrst_i <= 0;
		mode_i <= m;
		repeat (12) @(posedge core_clk_i);
		nrst_i <= 1;
		@(negedge core_clk_i);
		chk(p1_oe, oe);
		chk(p2_oe, oe);
		chk(p3_oe, 8'h00);
		rd(16'hFFB2);
		chk(q, 8'h00);
		rd(16'hFFB3);
		chk(q, 8'h00);
	endtask
	task t_dirs;
		wr(16'hFFB2, 8'hA5);
		wr(16'hFFB0, 8'hF0);
		wr(16'hFFB3, 8'h3C);
		wr(16'hFFB1, 8'h0F);
		@(negedge core_clk_i);
		chk(p1_oe, 8'hF0);
		chk(p2_oe, 8'h0F);
		chk(pin[7:0], 8'hAF);
		chk(pin[15:8], 8'hFC);
		rd(16'hFFB0);
		chk(q, 8'h00);
		rd(16'hFFB3);
		chk(q, 8'h3C);
		@(negedge core_clk_i);
		chk(rdata_o, 8'h00);
	endtask
	task t_port3;
		wr(16'hFFB4, 8'h81);
		@(negedge core_clk_i);
		chk(p3_oe, 8'h81);
		chk(pin[23:16], 8'hFE);
		rd(16'hFFB4);
		chk(q, 8'h00);
		rd(16'hFFB5);
		chk(q, 8'h00);
	endtask
	task t_mode1;
		wr(16'hFFB0, 8'h00);
		wr(16'hFFB1, 8'h00);
		wr(16'hFFB2, 8'h5A);
		@(negedge core_clk_i);
		chk(p1_oe & p2_oe, 8'hFF);
		chk(pin[7:0], 8'h5A);
	endtask
	task end_sim;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		t_reset(2'h3, 8'h00);
		t_dirs;
		t_port3;
		t_reset(2'h2, 8'h00);
		t_reset(2'h1, 8'hFF);
		t_mode1;
		end_sim;
	end
	initial begin
		#100000;
		n_fail++;
		end_sim;
	end
endmodule
